/* hw/ufc_map.vh */
// Purpose: register indices, field positions and reset values for ufc
// Assumes: 16550-style 3-bit address plus bank select from line_control
// Notes:   definitions only
`ifndef UFC_MAP_VH
`define UFC_MAP_VH
// register indices (byte address = index, plain port)
`define UFC_A_IER      3'h1
`define UFC_A_ISR      3'h2
`define UFC_A_FCR      3'h2
`define UFC_A_LCR      3'h3
`define UFC_A_MCR      3'h4
`define UFC_A_MSR      3'h6
`define UFC_A_SCR      3'h7
// enhanced bank, reached when line_control == 8'hBF
`define UFC_A_EFR      3'h2
`define UFC_A_FEATURE_CONTROL     3'h1
`define UFC_A_TRG      3'h0
// on/off characters live in the enhanced bank
`define UFC_A_FIRST_ON_CHAR     3'h4
`define UFC_A_SECOND_ON_CHAR     3'h5
`define UFC_A_FIRST_OFF_CHAR    3'h6
`define UFC_A_SECOND_OFF_CHAR    3'h7
`define UFC_BANK_KEY   8'hBF
// enhanced feature fields
`define UFC_EF_ENH     4
`define UFC_EF_SPEC    5
`define UFC_EF_ARTS    6
`define UFC_EF_ACTS    7
// feature control fields
`define UFC_FC_IRPOL   2
`define UFC_FC_DIR     3
`define UFC_FC_CNT     6
`define UFC_FC_TRGSEL  7
// modem control fields
`define UFC_MC_DTR     0
`define UFC_MC_RTS     1
`define UFC_MC_OUT1    2
`define UFC_MC_OUT2    3
`define UFC_MC_LOOP    4
// hysteresis above the trigger level, in characters
`define UFC_HYST_4     4'h4
`define UFC_HYST_6     4'h6
`define UFC_HYST_8     4'h8
// reset values
`define UFC_RST_ZERO   8'h00
`define UFC_RST_SCR    8'hFF
`endif

/* hw/ufc_core.v */
// Purpose: enhanced flow-control and feature registers of a 16550-type uart
// Assumes: datapath (shifter, fifos) outside; pins synchronised here
// Notes:   read data valid the cycle after rd_stb and held until the next rd_stb
//
// Decided for this implementation: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "ufc_map.vh"

module ufc_core #(
	parameter CW = 8
) (
	// clock and reset
	input  wire          ref_clk,
	input  wire          nrst,
	// register port
	input  wire [2:0]    addr,
	input  wire [7:0]    wdata,
	input  wire          wr_stb,
	input  wire          rd_stb,
	output reg  [7:0]    rdata,
	// datapath status (same clock)
	input  wire [CW-1:0] rx_count,
	input  wire [CW-1:0] tx_count,
	input  wire [CW-1:0] rx_trig,
	input  wire          rx_char_stb,
	input  wire [7:0]    rx_char,
	input  wire          tx_load_stb,
	input  wire          thr_empty,
	input  wire          tsr_empty,
	input  wire          bit_tick,
	input  wire          ir_rx_in,
	// modem pins (asynchronous)
	input  wire          clear_to_send_n,
	input  wire          data_set_ready_n,
	input  wire          ring_indicator_n,
	input  wire          carrier_detect_n,
	// modem pin outputs
	output reg           request_to_send_n,
	output reg           terminal_ready_n,
	output reg           out1_n,
	output reg           out2_n,
	// controls to datapath
	output reg           tx_halt,
	output reg           tx_irq,
	output reg           rx_trig_irq,
	output reg           ir_rx_data,
	output reg  [1:0]    tx_flow_sel,
	output reg  [1:0]    rx_flow_sel,
	output reg           tx_dual_seq,
	output reg           rx_dual_seq,
	output reg  [1:0]    trig_table,
	output reg  [7:0]    rx_trig_custom,
	output reg  [7:0]    tx_trig_custom,
	output reg  [2:0]    mode_select,
	output reg  [7:0]    ier_o,
	output reg  [7:0]    fcr_o,
	output reg  [7:0]    mcr_o
);

	// pin synchronisers
	reg [3:0] pin_s1_r;
	reg [3:0] pin_s2_r;
	reg       ir_s1_r;
	reg       ir_s2_r;

	// registers
	reg [7:0] lcr_r;
	reg [7:0] ier_r;
	reg [7:0] fcr_r;
	reg [7:0] mcr_r;
	reg [7:0] efr_r;
	reg [7:0] feature_control_r;
	reg [7:0] scr_r;
	reg [7:0] first_on_char_r;
	reg [7:0] second_on_char_r;
	reg [7:0] first_off_char_r;
	reg [7:0] second_off_char_r;
	reg       spec_flag_r;
	reg [3:0] sav_ier_r;
	reg       sav_isr_r;
	reg [1:0] sav_fcr_r;
	reg [2:0] sav_mcr_r;
	reg       auto_rts_hold_r;
	reg       dir_wait_r;
	reg       tsr_empty_d_r;

	wire cts_i = ~pin_s2_r[0];
	wire bank  = (lcr_r == `UFC_BANK_KEY);
	wire enh   = efr_r[`UFC_EF_ENH];
	wire loopb = mcr_r[`UFC_MC_LOOP];

	// returns 1 if wr targets idx in the given bank
	function hit;
		input [2:0] a;
		input [2:0] idx;
		input       b;
		input       want;
		begin
			hit = (a == idx) && (b == want);
		end
	endfunction

	wire w_ier   = wr_stb && hit(addr, `UFC_A_IER, bank, 1'b0);
	wire w_fcr   = wr_stb && hit(addr, `UFC_A_FCR, bank, 1'b0);
	wire w_lcr   = wr_stb && (addr == `UFC_A_LCR);
	wire w_mcr   = wr_stb && hit(addr, `UFC_A_MCR, bank, 1'b0);
	wire w_scr   = wr_stb && hit(addr, `UFC_A_SCR, bank, 1'b0);
	wire w_efr   = wr_stb && hit(addr, `UFC_A_EFR, bank, 1'b1);
	wire w_feature_control  = wr_stb && hit(addr, `UFC_A_FEATURE_CONTROL, bank, 1'b1);
	wire w_trg   = wr_stb && hit(addr, `UFC_A_TRG, bank, 1'b1);

	// hysteresis added to the trigger level
	reg [CW-1:0] hyst;
	always @*
	begin
		case (feature_control_r[1:0])
		2'b01:   hyst = {{(CW-4){1'b0}}, `UFC_HYST_4};
		2'b10:   hyst = {{(CW-4){1'b0}}, `UFC_HYST_6};
		2'b11:   hyst = {{(CW-4){1'b0}}, `UFC_HYST_8};
		default: hyst = {CW{1'b0}};
		endcase
	end
	wire [CW:0] upper = {1'b0, rx_trig} + {1'b0, hyst};
	// "next trigger level" approximated as trigger plus hyst
	wire rts_up   = ({1'b0, rx_count} >= upper) && (|rx_count);
	wire rts_down = (rx_count < rx_trig);

	// modem status upper nibble
	reg [3:0] msr_hi;
	always @*
	begin
		if (loopb)
			msr_hi = {mcr_r[`UFC_MC_OUT2], mcr_r[`UFC_MC_OUT1],
				mcr_r[`UFC_MC_DTR], mcr_r[`UFC_MC_RTS]};
		else
			msr_hi = ~pin_s2_r;
	end

	reg [7:0] rd_nxt;
	always @*
	begin
		rd_nxt = 8'h00;
		if (bank)
		begin
			case (addr)
			`UFC_A_EFR:   rd_nxt = efr_r;
			`UFC_A_FEATURE_CONTROL:  rd_nxt = feature_control_r;
			`UFC_A_LCR:   rd_nxt = lcr_r;
			`UFC_A_TRG:   rd_nxt = feature_control_r[`UFC_FC_TRGSEL] ?
				tx_count[7:0] : rx_count[7:0];
			`UFC_A_FIRST_ON_CHAR:  rd_nxt = first_on_char_r;
			`UFC_A_SECOND_ON_CHAR:  rd_nxt = second_on_char_r;
			`UFC_A_FIRST_OFF_CHAR: rd_nxt = first_off_char_r;
			`UFC_A_SECOND_OFF_CHAR: rd_nxt = second_off_char_r;
			default:      rd_nxt = 8'h00;
			endcase
		end
		else
		begin
			case (addr)
			`UFC_A_IER: rd_nxt = ier_r;
			`UFC_A_ISR: rd_nxt = {3'b000, spec_flag_r & ier_r[4],
				4'h1};
			`UFC_A_LCR: rd_nxt = lcr_r;
			`UFC_A_MCR: rd_nxt = mcr_r;
			`UFC_A_MSR: rd_nxt = {msr_hi, 4'h0};
			`UFC_A_SCR:
				if (feature_control_r[`UFC_FC_CNT])
					rd_nxt = mode_select[0] ? tx_count[7:0]
						: rx_count[7:0];
				else
					rd_nxt = scr_r;
			default:    rd_nxt = 8'h00;
			endcase
		end
	end

	always @(posedge ref_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pin_s1_r          <= 4'hF;
			pin_s2_r          <= 4'hF;
			ir_s1_r           <= 1'b0;
			ir_s2_r           <= 1'b0;
			lcr_r             <= `UFC_RST_ZERO;
			ier_r             <= `UFC_RST_ZERO;
			fcr_r             <= `UFC_RST_ZERO;
			mcr_r             <= `UFC_RST_ZERO;
			efr_r             <= `UFC_RST_ZERO;
			feature_control_r            <= `UFC_RST_ZERO;
			scr_r             <= `UFC_RST_SCR;
			first_on_char_r            <= `UFC_RST_ZERO;
			second_on_char_r            <= `UFC_RST_ZERO;
			first_off_char_r           <= `UFC_RST_ZERO;
			second_off_char_r           <= `UFC_RST_ZERO;
			spec_flag_r       <= 1'b0;
			sav_ier_r         <= 4'h0;
			sav_isr_r         <= 1'b0;
			sav_fcr_r         <= 2'h0;
			sav_mcr_r         <= 3'h0;
			auto_rts_hold_r   <= 1'b0;
			dir_wait_r        <= 1'b0;
			tsr_empty_d_r     <= 1'b1;
			rdata             <= 8'h00;
			request_to_send_n <= 1'b1;
			terminal_ready_n  <= 1'b1;
			out1_n            <= 1'b1;
			out2_n            <= 1'b1;
			tx_halt           <= 1'b0;
			tx_irq            <= 1'b0;
			rx_trig_irq       <= 1'b0;
			ir_rx_data        <= 1'b0;
			tx_flow_sel       <= 2'b00;
			rx_flow_sel       <= 2'b00;
			tx_dual_seq       <= 1'b0;
			rx_dual_seq       <= 1'b0;
			trig_table        <= 2'b00;
			rx_trig_custom    <= 8'h00;
			tx_trig_custom    <= 8'h00;
			mode_select       <= 3'h0;
			ier_o             <= 8'h00;
			fcr_o             <= 8'h00;
			mcr_o             <= 8'h00;
		end
		else
		begin
			pin_s1_r <= {carrier_detect_n, ring_indicator_n,
				data_set_ready_n, clear_to_send_n};
			pin_s2_r <= pin_s1_r;
			ir_s1_r  <= ir_rx_in;
			ir_s2_r  <= ir_s1_r;
			tsr_empty_d_r <= tsr_empty;
			if (rd_stb)
				rdata <= rd_nxt;
			if (w_lcr)
				lcr_r <= wdata;
			// gated bits only take register writes while enhance is set
			if (w_ier)
				ier_r <= enh ? wdata : {ier_r[7:4], wdata[3:0]};
			if (w_fcr)
				fcr_r <= enh ? wdata : {wdata[7:6], fcr_r[5:4],
					wdata[3:0]};
			if (w_mcr)
				mcr_r <= enh ? wdata : {mcr_r[7:5], wdata[4:0]};
			if (w_efr)
			begin
				efr_r <= wdata;
				if (enh && !wdata[`UFC_EF_ENH])
				begin
					sav_ier_r <= ier_r[7:4];
					sav_isr_r <= spec_flag_r;
					sav_fcr_r <= fcr_r[5:4];
					sav_mcr_r <= mcr_r[7:5];
					ier_r[7:4] <= 4'h0;
					fcr_r[5:4] <= 2'h0;
					mcr_r[7:5] <= 3'h0;
				end
				else if (!enh && wdata[`UFC_EF_ENH])
				begin
					ier_r[7:4] <= sav_ier_r;
					fcr_r[5:4] <= sav_fcr_r;
					mcr_r[7:5] <= sav_mcr_r;
				end
			end
			if (w_feature_control)
				feature_control_r <= wdata;
			if (w_scr)
			begin
				if (feature_control_r[`UFC_FC_CNT])
					mode_select <= wdata[2:0];
				else
					scr_r <= wdata;
			end
			if (w_trg)
			begin
				if (feature_control_r[`UFC_FC_TRGSEL])
					tx_trig_custom <= wdata;
				else
					rx_trig_custom <= wdata;
			end
			if (wr_stb && bank)
			begin
				case (addr)
				`UFC_A_FIRST_ON_CHAR:  first_on_char_r  <= wdata;
				`UFC_A_SECOND_ON_CHAR:  second_on_char_r  <= wdata;
				`UFC_A_FIRST_OFF_CHAR: first_off_char_r <= wdata;
				`UFC_A_SECOND_OFF_CHAR: second_off_char_r <= wdata;
				default:      first_on_char_r  <= first_on_char_r;
				endcase
			end
			// set wins over clear by read of status
			if (efr_r[`UFC_EF_SPEC] && rx_char_stb && rx_char == second_off_char_r)
				spec_flag_r <= 1'b1;
			else if (rd_stb && !bank && addr == `UFC_A_ISR)
				spec_flag_r <= 1'b0;
			else if (w_efr && enh && !wdata[`UFC_EF_ENH])
				spec_flag_r <= 1'b0;
			else if (w_efr && !enh && wdata[`UFC_EF_ENH])
				spec_flag_r <= sav_isr_r;
			// auto rts hysteresis
			if (!efr_r[`UFC_EF_ARTS])
				auto_rts_hold_r <= 1'b0;
			else if (rts_up)
				auto_rts_hold_r <= 1'b1;
			else if (rts_down)
				auto_rts_hold_r <= 1'b0;
			request_to_send_n <= ~mcr_r[`UFC_MC_RTS] | auto_rts_hold_r;
			rx_trig_irq <= efr_r[`UFC_EF_ARTS] && (rx_count >= rx_trig)
				&& (|rx_count);
			terminal_ready_n <= ~mcr_r[`UFC_MC_DTR];
			out2_n <= ~mcr_r[`UFC_MC_OUT2];
			// halt only between characters, shifter enforces boundary
			tx_halt <= efr_r[`UFC_EF_ACTS] && !cts_i;
			// direction control on out1_n
			if (feature_control_r[`UFC_FC_DIR])
			begin
				if (tx_load_stb)
				begin
					dir_wait_r <= 1'b0;
					out1_n     <= 1'b0;
				end
				else if (tsr_empty && !tsr_empty_d_r && thr_empty)
					dir_wait_r <= 1'b1;
				else if (dir_wait_r && bit_tick)
				begin
					dir_wait_r <= 1'b0;
					out1_n     <= 1'b1;
				end
			end
			else
			begin
				dir_wait_r <= 1'b0;
				out1_n     <= ~mcr_r[`UFC_MC_OUT1];
			end
			tx_irq <= feature_control_r[`UFC_FC_DIR] ? (thr_empty && tsr_empty)
				: thr_empty;
			ir_rx_data <= feature_control_r[`UFC_FC_IRPOL] ? ir_s2_r : ~ir_s2_r;
			tx_flow_sel <= efr_r[3:2];
			rx_flow_sel <= efr_r[1:0];
			tx_dual_seq <= &efr_r[3:2];
			rx_dual_seq <= &efr_r[1:0];
			trig_table  <= feature_control_r[5:4];
			ier_o <= ier_r;
			fcr_o <= fcr_r;
			mcr_o <= mcr_r;
		end
	end

endmodule
`default_nettype wire

/* dv/ufc_modem.sv */
// Purpose: far-side modem model driving the status pins of ufc_core
// Assumes: bench chooses pin levels; slow mode settles a cycle late
// Notes:   pins order in lvl is {cd, ri, dsr, cts}
`timescale 1ns/1ps
`default_nettype none
module ufc_modem (
	input  wire logic       ref_clk,
	input  wire logic       slow,
	input  wire logic [3:0] lvl,
	output logic            clear_to_send_n,
	output logic            data_set_ready_n,
	output logic            ring_indicator_n,
	output logic            carrier_detect_n
);
	logic [3:0] d_r;
	always @(posedge ref_clk)
		d_r <= lvl;
	// late mode lands on the next clock edge, so the sync sees edges one cycle late
	assign {carrier_detect_n, ring_indicator_n, data_set_ready_n,
		clear_to_send_n} = slow ? d_r : lvl;
endmodule
`default_nettype wire

/* dv/ufc_core_sva.sv */
// Purpose: port checker for ufc_core
// Assumes: shadows line_control, enhanced and feature writes
// Notes:   bound below the module
`timescale 1ns/1ps
`default_nettype none
module ufc_core_sva #(
	parameter CW = 8
) (
	// clock and reset
	input wire logic          ref_clk,
	input wire logic          nrst,
	// register port
	input wire logic          wr_stb,
	input wire logic          rd_stb,
	input wire logic [2:0]    addr,
	input wire logic [7:0]    wdata,
	input wire logic [7:0]    rdata,
	// datapath side
	input wire logic [CW-1:0] rx_count,
	input wire logic [CW-1:0] rx_trig,
	input wire logic          tx_load_stb,
	input wire logic          tsr_empty,
	input wire logic          bit_tick,
	// modem side
	input wire logic          clear_to_send_n,
	input wire logic          request_to_send_n,
	input wire logic          out1_n,
	// controls and register copies
	input wire logic          tx_halt,
	input wire logic          tx_irq,
	input wire logic          tx_dual_seq,
	input wire logic          rx_dual_seq,
	input wire logic [1:0]    tx_flow_sel,
	input wire logic [1:0]    rx_flow_sel,
	input wire logic [7:0]    mcr_o
);
	logic [7:0] lcr_r, efr_r, fct_r;
	logic [CW:0] up;
	wire bk = lcr_r == 8'hBF;
	assign up = rx_trig + (fct_r[1:0] == 2'h0 ? 4'h0 :
		{1'b0, fct_r[1:0], 1'b0} + 4'h2);
	always_ff @(posedge ref_clk or negedge nrst)
		if (!nrst)
		begin
			lcr_r <= 8'h00;
			efr_r <= 8'h00;
			fct_r <= 8'h00;
		end
		else if (wr_stb)
		begin
			if (addr == 3'h3)
				lcr_r <= wdata;
			if (bk && addr == 3'h2)
				efr_r <= wdata;
			if (bk && addr == 3'h1)
				fct_r <= wdata;
		end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	wire arts = efr_r[6] && mcr_o[1] && !mcr_o[4];
	sequence s_drained;
		(fct_r[3] && tsr_empty && !tx_load_stb)[*2] ##0 bit_tick;
	endsequence
	rts_high_a: assert property ((arts && {1'b0, rx_count} >= up)[*3]
		|-> request_to_send_n) else $error("rts not raised");
	rts_low_a: assert property ((arts && rx_count < rx_trig)[*3]
		|-> !request_to_send_n) else $error("rts not lowered");
	// three cycles: a hold left from auto mode drains one cycle late
	rts_follow_a: assert property ((!efr_r[6] && !mcr_o[4])[*3]
		|-> request_to_send_n == !mcr_o[1]) else $error("rts pin");
	cts_halt_a: assert property ((efr_r[7] && clear_to_send_n)[*5]
		|-> tx_halt) else $error("no halt");
	cts_go_a: assert property ((efr_r[7] && !clear_to_send_n)[*5]
		|-> !tx_halt) else $error("no resume");
	dir_load_a: assert property (fct_r[3] && tx_load_stb
		|-> ##[1:2] !out1_n) else $error("dir not restored");
	dir_idle_a: assert property (s_drained |-> ##[1:2] out1_n)
		else $error("dir not released");
	irq_hold_a: assert property ((fct_r[3] && !tsr_empty)[*3]
		|-> !tx_irq) else $error("early tx irq");
	flow_sel_a: assert property (wr_stb && bk && addr == 3'h2 |-> ##2
		{tx_flow_sel, rx_flow_sel, tx_dual_seq, rx_dual_seq} ==
		{$past(wdata[3:0], 2), &$past(wdata[3:2], 2),
		&$past(wdata[1:0], 2)}) else $error("flow select");
	loop_map_a: assert property (rd_stb && addr == 3'h6 && !bk && mcr_o[4]
		&& !$past(wr_stb) |=> rdata[7:4] ==
		{mcr_o[3], mcr_o[2], mcr_o[0], mcr_o[1]}) else $error("loop map");
endmodule
bind ufc_core ufc_core_sva #(.CW(CW)) ufc_core_sva_i (.ref_clk, .nrst,
	.wr_stb, .rd_stb, .addr, .wdata, .rdata, .mcr_o, .rx_count, .rx_trig,
	.clear_to_send_n, .tx_load_stb, .tsr_empty, .bit_tick,
	.request_to_send_n, .out1_n, .tx_halt, .tx_irq, .tx_dual_seq,
	.rx_dual_seq, .tx_flow_sel, .rx_flow_sel);
`default_nettype wire

/* dv/ufc_core_tb.sv */
// Purpose: self-checking bench for ufc_core
// Assumes: one clock, register port with read data a cycle later
// Notes:   reads queue their expectation; a watcher compares
`timescale 1ns/1ps
`default_nettype none
module ufc_core_tb;
	logic        ref_clk = 0, nrst = 0, wr_stb = 0, rd_stb = 0, slow = 0;
	logic [2:0]  addr = 0;
	logic [7:0]  wdata = 0, rdata, x, y, rx_char = 0, rxc, txc;
	logic [7:0]  rx_count = 0, tx_count = 0, rx_trig = 8'h10;
	logic        rx_char_stb = 0, tx_load_stb = 0, tsr_empty = 1;
	logic        bit_tick = 0, ir_rx_in = 0, pend = 0;
	logic [3:0]  lvl = 4'hF;
	logic        cts_n, dsr_n, ri_n, cd_n, rts_n, out1_n, tx_halt;
	logic        thr_empty = 1, trn, o2n, txirq, rtirq, ird, e1;
	logic [2:0]  ms, ir_h = 0;
	logic [7:0]  iero, fcro;
	logic [1:0]  tt;
	logic [15:0] q[$];
	int          fails = 0, comparisons = 0, sd = 66;
	always #5 ref_clk = ~ref_clk;
	ufc_modem ufc_modem_i (.ref_clk, .slow, .lvl, .clear_to_send_n(cts_n),
		.data_set_ready_n(dsr_n), .ring_indicator_n(ri_n),
		.carrier_detect_n(cd_n));
	ufc_core ufc_core_i (.ref_clk, .nrst, .addr, .wdata, .wr_stb, .rd_stb,
		.rdata, .rx_count, .tx_count, .rx_trig, .rx_char_stb, .rx_char,
		.tx_load_stb, .thr_empty, .tsr_empty, .bit_tick,
		.ir_rx_in, .clear_to_send_n(cts_n), .data_set_ready_n(dsr_n),
		.ring_indicator_n(ri_n), .carrier_detect_n(cd_n),
		.request_to_send_n(rts_n), .terminal_ready_n(trn), .out1_n,
		.out2_n(o2n), .tx_halt, .tx_irq(txirq), .rx_trig_irq(rtirq),
		.ir_rx_data(ird), .tx_flow_sel(), .rx_flow_sel(), .tx_dual_seq(),
		.rx_dual_seq(), .trig_table(tt), .rx_trig_custom(rxc),
		.tx_trig_custom(txc), .mode_select(ms), .ier_o(iero), .fcr_o(fcro),
		.mcr_o());
	task automatic chk(input logic [7:0] got, input logic [15:0] e);
		comparisons++;
		if ((got & e[7:0]) !== (e[15:8] & e[7:0]))
		begin
			fails++;
			$display("[ERR] %0t got %h want %h", $time, got, e[15:8]);
		end
	endtask
	task automatic bus(input logic w, input logic [2:0] a,
		input logic [7:0] d);
		wr_stb <= w;
		rd_stb <= !w;
		addr <= a;
		wdata <= d;
		@(posedge ref_clk);
	endtask
	task automatic rd(input logic [2:0] a, input logic [15:0] e);
		q.push_back(e);
		bus(0, a, 8'h00);
	endtask
	task automatic nop(input int n);
		wr_stb <= 0;
		rd_stb <= 0;
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic enhanced_feature_control(input logic [7:0] v);
		bus(1, 3'h3, 8'hBF);
		bus(1, 3'h2, v);
		bus(1, 3'h3, 8'h00);
	endtask
	task automatic end_sim;
		$display("counts fails %0d comparisons %0d", fails, comparisons);
		if (fails == 0 && comparisons > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// read data stands from the cycle after the strobe until the next read
	always @(posedge ref_clk)
	begin
		if (pend)
			chk(rdata, q.pop_front());
		pend <= rd_stb;
		bit_tick <= ($time / 10) % 16 == 0;
		ir_rx_in <= $random(sd);
		ir_h <= {ir_h[1:0], ir_rx_in};
	end
	initial
	begin
		#100000;
		fails++;
		end_sim();
	end
	initial
	begin
		repeat (5) @(posedge ref_clk);
		nrst <= 1;
		@(posedge ref_clk);
		rd(3'h7, 16'hFFFF);
		x = $random(sd);
		bus(1, 3'h7, x);
		rd(3'h7, {x, 8'hFF});
		for (int i = 0; i < 2; i++)
		begin
			slow <= i[0];
			lvl <= $random(sd);
			nop(6);
			rd(3'h6, {~lvl, 12'hF0});
		end
		bus(1, 3'h4, {4'h1, x[3:0]});
		nop(1);
		rd(3'h6, {x[3], x[2], x[0], x[1], 12'hF0});
		chk({6'h0, trn, o2n}, {6'h0, ~x[0], ~x[3], 8'h03});
		bus(1, 3'h4, 8'h02);
		$display("modem status done");
		bus(1, 3'h3, 8'hBF);
		for (int i = 0; i < 16; i++)
		begin
			bus(1, 3'h2, i[7:0]);
			rd(3'h2, {i[7:0], 8'hFF});
		end
		bus(1, 3'h2, 8'h00);
		bus(1, 3'h3, 8'h00);
		rd(3'h1, 16'h00FF);
		bus(1, 3'h1, 8'hF5);
		rd(3'h1, 16'h05FF);
		enhanced_feature_control(8'h10);
		bus(1, 3'h1, 8'hF5);
		rd(3'h1, 16'hF5FF);
		enhanced_feature_control(8'h00);
		rd(3'h1, 16'h05FF);
		bus(1, 3'h2, 8'hF7);
		bus(1, 3'h2, 8'h07);
		nop(2);
		chk(fcro, 16'h07FF);
		enhanced_feature_control(8'h10);
		rd(3'h1, 16'hF5FF);
		chk(iero, 16'hF5FF);
		$display("gating done");
		y = $random(sd);
		bus(1, 3'h3, 8'hBF);
		bus(1, 3'h7, y);
		enhanced_feature_control(8'h30);
		for (int i = 0; i < 2; i++)
		begin
			rx_char <= i ? y : ~y;
			rx_char_stb <= 1;
			nop(1);
			rx_char_stb <= 0;
			nop(3);
			rd(3'h2, {3'h0, i[0], 12'h111});
		end
		rd(3'h2, 16'h0111);
		$display("special char done");
		rx_count <= $random(sd);
		tx_count <= $random(sd);
		bus(1, 3'h3, 8'hBF);
		bus(1, 3'h1, 8'h40);
		bus(1, 3'h3, 8'h00);
		rd(3'h7, {rx_count, 8'hFF});
		bus(1, 3'h7, 8'h01);
		rd(3'h7, {tx_count, 8'hFF});
		chk({5'h0, ms}, 16'h0107);
		bus(1, 3'h3, 8'hBF);
		for (int i = 0; i < 4; i++)
		begin
			bus(1, 3'h1, {i[0], 1'b0, i[1:0], 4'h0});
			bus(1, 3'h0, x ^ i[7:0]);
			nop(2);
			chk({6'h0, tt}, {6'h0, i[1:0], 8'h03});
			chk(i[0] ? txc : rxc, {x ^ i[7:0], 8'hFF});
			rd(3'h0, {i[0] ? tx_count : rx_count, 8'hFF});
		end
		for (int p = 0; p < 2; p++)
		begin
			bus(1, 3'h1, {5'h0, p[0], 2'h0});
			nop(3);
			chk({7'h0, ird}, {7'h0, p[0] ~^ ir_h[2], 8'h01});
		end
		$display("feature control done");
		enhanced_feature_control(8'hD0);
		bus(1, 3'h3, 8'hBF);
		for (int h = 0; h < 4; h++)
		begin
			bus(1, 3'h1, h[7:0]);
			y = 8'(16 + ((h == 0) ? 0 : 2 * h + 2));
			for (int j = 0; j < 3; j++)
			begin
				rx_count <= (j == 1) ? y : (j == 0) ? y - 1 : 8'h0F;
				nop(4);
				e1 = (j == 1) || (j == 0 && y > 16);
				chk({6'h0, rts_n, rtirq}, {6'h0, j == 1, e1, 8'h03});
			end
		end
		for (int i = 0; i < 2; i++)
		begin
			lvl <= {3'h7, i[0]};
			nop(6);
			chk({7'h0, tx_halt}, {7'h0, i[0], 8'h01});
		end
		bus(1, 3'h1, 8'h08);
		tsr_empty <= 0;
		tx_load_stb <= 1;
		nop(1);
		tx_load_stb <= 0;
		nop(3);
		chk({6'h0, out1_n, txirq}, 16'h0003);
		nop(20);
		tsr_empty <= 1;
		nop(40);
		chk({6'h0, out1_n, txirq}, 16'h0303);
		bus(1, 3'h1, 8'h00);
		tsr_empty <= 0;
		nop(3);
		chk({7'h0, txirq}, 16'h0101);
		tsr_empty <= 1;
		$display("flow control done");
		nrst <= 0;
		nop(2);
		nrst <= 1;
		nop(1);
		rd(3'h1, 16'h00FF);
		rd(3'h4, 16'h00FF);
		$display("reset done");
		nop(2);
		end_sim();
	end
endmodule
`default_nettype wire
